// File: logic/dcr_pkg.sv
`default_nettype none

package dcr_pkg;

    // Register offsets on the control bus.
    localparam logic [7:0] OFS_FRAC_LO = 8'h64;
    localparam logic [7:0] OFS_FRAC_HI = 8'h65;
    localparam logic [7:0] OFS_TALLY_LO = 8'h67;
    localparam logic [7:0] OFS_TALLY_MID = 8'h68;
    localparam logic [7:0] OFS_TALLY_HI = 8'h69;
    localparam logic [7:0] OFS_MEAN_RATE = 8'h6A;
    localparam logic [7:0] OFS_FW_VERSION = 8'h71;
    localparam logic [7:0] OFS_DECODE_GO = 8'h72;
    localparam logic [7:0] OFS_HS_CORNER_LO = 8'h77;
    localparam logic [7:0] OFS_HS_CORNER_HI = 8'h78;
    localparam logic [7:0] OFS_LS_CORNER_LO = 8'h79;
    localparam logic [7:0] OFS_LS_CORNER_HI = 8'h7A;
    localparam logic [7:0] OFS_HS_GAIN = 8'h7B;
    localparam logic [7:0] OFS_LS_GAIN = 8'h7C;

    // Reset values.
    localparam logic [7:0] FRAC_LO_RST = 8'h46;
    localparam logic [7:0] FRAC_HI_RST = 8'h5B;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [23:0] TALLY_RST = 24'h000000;

    // Field positions.
    localparam int DECODE_GO_BIT = 0;
    localparam int FRAC_HI_SHIFT = 8;

    // Gain limit in 1.5 dB steps: 12 steps is 18 dB.
    localparam logic [7:0] GAIN_STEP_LIMIT = 8'h0C;

    // Control bus slave address and byte framing.
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h43;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Control bus slave states.
    typedef enum logic [3:0] {
        DCR_IDLE = 4'b0000,
        DCR_ADDR = 4'b0001,
        DCR_ADDR_ACK = 4'b0010,
        DCR_PTR = 4'b0011,
        DCR_PTR_ACK = 4'b0100,
        DCR_WDATA = 4'b0101,
        DCR_WDATA_ACK = 4'b0110,
        DCR_RDATA = 4'b0111,
        DCR_RDATA_ACK = 4'b1000
    } dcr_bus_e;

endpackage : dcr_pkg

`default_nettype wire

// File: logic/dcr_gain_limit.sv
`timescale 1ns/1ps
`default_nettype none

// Clamps a signed step count to the allowed boost and cut range.
module dcr_gain_limit (
    input wire logic [7:0] gain_raw,
    output logic [7:0] gain_steps
);
    import dcr_pkg::*;

    // Out-of-range requests saturate so the filter never sees more than 18 dB.
    always_comb begin
        if ($signed(gain_raw) > $signed(GAIN_STEP_LIMIT)) begin
            gain_steps = GAIN_STEP_LIMIT;
        end else if ($signed(gain_raw) < -$signed(GAIN_STEP_LIMIT)) begin
            gain_steps = 8'(-$signed(GAIN_STEP_LIMIT));
        end else begin
            gain_steps = gain_raw;
        end
    end

endmodule : dcr_gain_limit

`default_nettype wire

// File: logic/dcr_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_control_regs #(
    parameter logic [6:0] BUS_ADDR = dcr_pkg::BUS_ADDR_DEFAULT,
    parameter logic [7:0] FW_VERSION = 8'hA5 // Arbitrary value.
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic frame_decoded,
    input wire logic frame_sync,
    input wire logic [15:0] sync_fraction,
    input wire logic [7:0] bitrate_kbps,
    input wire logic boot_done,
    output logic [15:0] pll_fraction,
    output logic [23:0] frame_tally,
    output logic decode_run,
    output logic [15:0] high_shelf_corner,
    output logic [15:0] low_shelf_corner,
    output logic [7:0] high_shelf_gain,
    output logic [7:0] low_shelf_gain
);
    import dcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State of the whole block.

    typedef struct packed {
        dcr_bus_e st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic [7:0] ptr;
        logic sda_oe;
        logic sda_out;
        logic scl_q;
        logic sda_q;
        logic sync_q;
        logic [7:0] frac_lo;
        logic [7:0] frac_hi;
        logic [23:0] tally;
        logic [7:0] rate;
        logic [7:0] version;
        logic run;
        logic [7:0] hs_lo;
        logic [7:0] hs_hi;
        logic [7:0] ls_lo;
        logic [7:0] ls_hi;
        logic [7:0] hs_gain;
        logic [7:0] ls_gain;
        logic [7:0] hs_steps;
        logic [7:0] ls_steps;
    } dcr_state_s;

    localparam dcr_state_s RST_STATE = '{
        st: DCR_IDLE,
        frac_lo: FRAC_LO_RST,
        frac_hi: FRAC_HI_RST,
        scl_q: 1'b1,
        sda_q: 1'b1,
        default: '0
    };

    dcr_state_s state_r;
    dcr_state_s state_nxt;
    logic [7:0] hs_steps_lim;
    logic [7:0] ls_steps_lim;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_byte;
    logic [7:0] rd_next;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register read decode; unmapped offsets and unused bits read as zero.

    function automatic logic [7:0] read_reg(input dcr_state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = BYTE_RST;
        case (a)
            OFS_FRAC_LO: v = s.frac_lo;
            OFS_FRAC_HI: v = s.frac_hi;
            OFS_TALLY_LO: v = s.tally[7:0];
            OFS_TALLY_MID: v = s.tally[15:8];
            OFS_TALLY_HI: v = s.tally[23:16];
            OFS_MEAN_RATE: v = s.rate;
            OFS_FW_VERSION: v = s.version;
            OFS_DECODE_GO: v[DECODE_GO_BIT] = s.run;
            OFS_HS_CORNER_LO: v = s.hs_lo;
            OFS_HS_CORNER_HI: v = s.hs_hi;
            OFS_LS_CORNER_LO: v = s.ls_lo;
            OFS_LS_CORNER_HI: v = s.ls_hi;
            OFS_HS_GAIN: v = s.hs_gain;
            OFS_LS_GAIN: v = s.ls_gain;
            default: v = BYTE_RST;
        endcase
        return v;
    endfunction : read_reg

    assign rd_byte = read_reg(state_r, state_r.ptr);
    assign rd_next = read_reg(state_r, state_r.ptr + 8'h01);

    // Bus pins are already synchronous, so edges come from one registered sample.
    assign scl_rise = scl_in & ~state_r.scl_q;
    assign scl_fall = ~scl_in & state_r.scl_q;
    assign bus_start = scl_in & state_r.scl_q & state_r.sda_q & ~sda_in;
    assign bus_stop = scl_in & state_r.scl_q & ~state_r.sda_q & sda_in;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Gain saturation, one instance per shelf.

    dcr_gain_limit u_hs_limit (
        .gain_raw(state_r.hs_gain),
        .gain_steps(hs_steps_lim)
    );

    dcr_gain_limit u_ls_limit (
        .gain_raw(state_r.ls_gain),
        .gain_steps(ls_steps_lim)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, host writes, hardware updates, soft reset.

    always_comb begin
        state_nxt = state_r;
        state_nxt.scl_q = scl_in;
        state_nxt.sda_q = sda_in;
        state_nxt.sync_q = frame_sync;
        state_nxt.sda_out = 1'b0;
        if (bus_start) begin
            state_nxt.st = DCR_ADDR;
            state_nxt.cnt = 4'h0;
            state_nxt.sda_oe = 1'b0;
        end else if (bus_stop) begin
            state_nxt.st = DCR_IDLE;
            state_nxt.sda_oe = 1'b0;
        end else begin
            unique case (state_r.st)
                DCR_IDLE: begin
                    state_nxt.sda_oe = 1'b0;
                end
                DCR_ADDR, DCR_PTR, DCR_WDATA: begin
                    if (scl_rise) begin
                        state_nxt.shreg = {state_r.shreg[6:0], sda_in};
                        state_nxt.cnt = state_r.cnt + 4'h1;
                    end else if (scl_fall && state_r.cnt == BITS_PER_BYTE) begin
                        state_nxt.sda_oe = 1'b1;
                        if (state_r.st == DCR_ADDR) begin
                            state_nxt.rw = state_r.shreg[0];
                            if (state_r.shreg[7:1] == BUS_ADDR) begin
                                state_nxt.st = DCR_ADDR_ACK;
                            end else begin
                                state_nxt.st = DCR_IDLE;
                                state_nxt.sda_oe = 1'b0;
                            end
                        end else if (state_r.st == DCR_PTR) begin
                            state_nxt.st = DCR_PTR_ACK;
                        end else begin
                            // Only writable bits are stored; read-only offsets drop the data.
                            unique case (state_r.ptr)
                                OFS_FRAC_LO: state_nxt.frac_lo = state_r.shreg;
                                OFS_FRAC_HI: state_nxt.frac_hi = state_r.shreg;
                                OFS_DECODE_GO: state_nxt.run = state_r.shreg[DECODE_GO_BIT];
                                OFS_HS_CORNER_LO: state_nxt.hs_lo = state_r.shreg;
                                OFS_HS_CORNER_HI: state_nxt.hs_hi = state_r.shreg;
                                OFS_LS_CORNER_LO: state_nxt.ls_lo = state_r.shreg;
                                OFS_LS_CORNER_HI: state_nxt.ls_hi = state_r.shreg;
                                OFS_HS_GAIN: state_nxt.hs_gain = state_r.shreg;
                                OFS_LS_GAIN: state_nxt.ls_gain = state_r.shreg;
                                default: state_nxt.run = state_r.run;
                            endcase
                            state_nxt.st = DCR_WDATA_ACK;
                        end
                    end
                end
                DCR_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_nxt.cnt = 4'h0;
                        if (state_r.rw) begin
                            state_nxt.shreg = rd_byte;
                            state_nxt.sda_oe = ~rd_byte[7];
                            state_nxt.st = DCR_RDATA;
                        end else begin
                            state_nxt.sda_oe = 1'b0;
                            state_nxt.st = DCR_PTR;
                        end
                    end
                end
                DCR_PTR_ACK: begin
                    if (scl_fall) begin
                        state_nxt.ptr = state_r.shreg;
                        state_nxt.cnt = 4'h0;
                        state_nxt.sda_oe = 1'b0;
                        state_nxt.st = DCR_WDATA;
                    end
                end
                DCR_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_nxt.ptr = state_r.ptr + 8'h01;
                        state_nxt.cnt = 4'h0;
                        state_nxt.sda_oe = 1'b0;
                        state_nxt.st = DCR_WDATA;
                    end
                end
                DCR_RDATA: begin
                    if (scl_rise) begin
                        state_nxt.cnt = state_r.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (state_r.cnt == BITS_PER_BYTE) begin
                            state_nxt.sda_oe = 1'b0;
                            state_nxt.st = DCR_RDATA_ACK;
                        end else begin
                            state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
                            state_nxt.sda_oe = ~state_r.shreg[6];
                        end
                    end
                end
                DCR_RDATA_ACK: begin
                    if (scl_rise) begin
                        // Bit 0 holds the master's acknowledge until the falling edge.
                        state_nxt.shreg[0] = sda_in;
                    end else if (scl_fall) begin
                        state_nxt.cnt = 4'h0;
                        if (!state_r.shreg[0]) begin
                            state_nxt.ptr = state_r.ptr + 8'h01;
                            state_nxt.shreg = rd_next;
                            state_nxt.sda_oe = ~rd_next[7];
                            state_nxt.st = DCR_RDATA;
                        end else begin
                            state_nxt.st = DCR_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt.st = DCR_IDLE;
                    state_nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // Reaching frame sync loads the operational fraction; it beats a host write.
        if (frame_sync && !state_r.sync_q) begin
            state_nxt.frac_lo = sync_fraction[7:0];
            state_nxt.frac_hi = sync_fraction[15:8];
        end

        // Frame tally and mean rate only move while decoding runs.
        if (frame_decoded && state_r.run) begin
            state_nxt.tally = state_r.tally + 24'h000001;
            state_nxt.rate = bitrate_kbps;
        end

        // The version code is hidden until the embedded firmware has booted.
        state_nxt.version = boot_done ? FW_VERSION : BYTE_RST;

        // Saturated step counts feed the shelf filters.
        state_nxt.hs_steps = hs_steps_lim;
        state_nxt.ls_steps = ls_steps_lim;

        // Software reset reloads every register except the version code; the bus slave keeps its place.
        if (soft_reset) begin
            state_nxt.frac_lo = FRAC_LO_RST;
            state_nxt.frac_hi = FRAC_HI_RST;
            state_nxt.tally = TALLY_RST;
            state_nxt.rate = BYTE_RST;
            state_nxt.run = 1'b0;
            state_nxt.hs_lo = BYTE_RST;
            state_nxt.hs_hi = BYTE_RST;
            state_nxt.ls_lo = BYTE_RST;
            state_nxt.ls_hi = BYTE_RST;
            state_nxt.hs_gain = BYTE_RST;
            state_nxt.ls_gain = BYTE_RST;
        end
    end

    // Hardware reset loads the same values, including the defined fraction low byte.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= RST_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.

    assign sda_out = state_r.sda_out;
    assign sda_oe = state_r.sda_oe;
    // The PLL forms its divisor from this fraction for the 48 kHz family.
    assign pll_fraction = (16'(state_r.frac_hi) << FRAC_HI_SHIFT) | 16'(state_r.frac_lo);
    assign frame_tally = state_r.tally;
    assign decode_run = state_r.run;
    assign high_shelf_corner = {state_r.hs_hi, state_r.hs_lo};
    assign low_shelf_corner = {state_r.ls_hi, state_r.ls_lo};
    assign high_shelf_gain = state_r.hs_steps;
    assign low_shelf_gain = state_r.ls_steps;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    frac_swreset_a: assert property (@(posedge clk) disable iff (reset)
        soft_reset |=> pll_fraction == 16'h5B46)
        else $error("fraction not reloaded by soft reset");

    frac_sync_a: assert property (@(posedge clk) disable iff (reset)
        (frame_sync && !state_r.sync_q && !soft_reset) |=> pll_fraction == $past(sync_fraction))
        else $error("fraction not loaded at frame sync");

    tally_step_a: assert property (@(posedge clk) disable iff (reset)
        (frame_decoded && decode_run && !soft_reset) |=> frame_tally == $past(frame_tally) + 24'h1)
        else $error("frame tally did not advance");

    tally_hold_a: assert property (@(posedge clk) disable iff (reset)
        (!frame_decoded && !soft_reset) |=> $stable(frame_tally))
        else $error("frame tally moved without a frame");

    tally_clear_a: assert property (@(posedge clk) disable iff (reset)
        soft_reset |=> frame_tally == 24'h0 && !decode_run)
        else $error("soft reset left tally or run set");

    rate_capture_a: assert property (@(posedge clk) disable iff (reset)
        (frame_decoded && decode_run && !soft_reset) |=> state_r.rate == $past(bitrate_kbps))
        else $error("mean rate not captured");

    version_gate_a: assert property (@(posedge clk) disable iff (reset)
        !boot_done |=> state_r.version == 8'h00)
        else $error("version visible before boot");

    hs_gain_range_a: assert property (@(posedge clk) disable iff (reset)
        $signed(high_shelf_gain) <= 8'sd12 && $signed(high_shelf_gain) >= -8'sd12)
        else $error("high shelf gain out of range");

    ls_gain_range_a: assert property (@(posedge clk) disable iff (reset)
        $signed(low_shelf_gain) <= 8'sd12 && $signed(low_shelf_gain) >= -8'sd12)
        else $error("low shelf gain out of range");

    unused_zero_a: assert property (@(posedge clk) disable iff (reset)
        state_r.ptr == OFS_DECODE_GO |-> rd_byte[7:1] == 7'h00)
        else $error("unused run bits read nonzero");

endmodule : dcr_control_regs

`default_nettype wire

// File: tb/dcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Control bus master in the place of the host; it only ever pulls SDA low.
module dcr_host_model (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low
);
    // The bus idles with both lines released.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Each phase lasts four clocks, twice the minimum the slave needs.
    task automatic half();
        repeat (4) @(posedge clk);
    endtask : half

    // Data only moves while SCL is low, so no false START or STOP is seen.
    task automatic put_bit(input logic b);
        sda_low <= ~b;
        half();
        scl <= 1'b1;
        half();
        scl <= 1'b0;
    endtask : put_bit

    // SDA is released so that the pull-up, not a stale level, shows.
    task automatic get_bit(output logic b);
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        b = sda_in;
        scl <= 1'b0;
    endtask : get_bit

    // Also serves as repeated START when SCL is low.
    task automatic start();
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask : stop

    task automatic send(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        ack = ~a;
    endtask : send

    // Writes one byte at pointer p; ok is high when every byte was acknowledged.
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic k1, k2, k3;
        start();
        send({a, 1'b0}, k1);
        send(p, k2);
        send(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : wr

    // Writes two bytes from pointer p upward in one transfer, low byte first.
    task automatic wr2(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                       output logic ok);
        logic k1, k2, k3, k4;
        start();
        send({a, 1'b0}, k1);
        send(p, k2);
        send(d[7:0], k3);
        send(d[15:8], k4);
        stop();
        ok = k1 & k2 & k3 & k4;
    endtask : wr2

    // Reads n bytes from pointer p upward, the first into the lowest byte of v.
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                      output logic [23:0] v);
        logic k, b;
        start();
        send({a, 1'b0}, k);
        send(p, k);
        start();
        send({a, 1'b1}, k);
        v = 24'h000000;
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) begin
                get_bit(b);
                v[8 * i + j] = b;
            end
            put_bit(i == n - 1);
        end
        stop();
    endtask : rd
endmodule : dcr_host_model

`default_nettype wire

// File: tb/dcr_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_control_regs_test;
    import dcr_pkg::*;
    localparam logic [7:0] FW_CODE = 8'h3C; // Arbitrary value.
    localparam logic [6:0] ADR = BUS_ADDR_DEFAULT;
    logic clk = 1'b0, reset = 1'b1, soft_reset = 1'b0, boot_done = 1'b0;
    logic frame_decoded = 1'b0, frame_sync = 1'b0;
    logic [15:0] sync_fraction = 16'h0000;
    logic [7:0] bitrate_kbps = 8'h00;
    logic scl, sda_low, sda_out, sda_oe, sda, decode_run;
    logic [15:0] pll_fraction, high_shelf_corner, low_shelf_corner;
    logic [23:0] frame_tally;
    logic [7:0] high_shelf_gain, low_shelf_gain;
    int n_mismatch = 0, checks_done = 0;
    int seed = 32'h13DA705C;

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain wire: high by pull-up unless a party pulls it low.
    assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    always #20 clk = ~clk;

    dcr_control_regs #(.FW_VERSION(FW_CODE)) dcr_control_regs_i (.clk(clk), .reset(reset),
        .soft_reset(soft_reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .frame_decoded(frame_decoded), .frame_sync(frame_sync),
        .sync_fraction(sync_fraction), .bitrate_kbps(bitrate_kbps), .boot_done(boot_done),
        .pll_fraction(pll_fraction), .frame_tally(frame_tally), .decode_run(decode_run),
        .high_shelf_corner(high_shelf_corner), .low_shelf_corner(low_shelf_corner),
        .high_shelf_gain(high_shelf_gain), .low_shelf_gain(low_shelf_gain));

    dcr_host_model host_i (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Gain seen by the filters: 12 steps of 1.5 dB make the 18 dB limit.
    function automatic logic [7:0] clamp(input logic [7:0] g);
        if ($signed(g) > 12) return 8'h0C;
        if ($signed(g) < -12) return 8'hF4;
        return g;
    endfunction : clamp

    // Sweeps the whole map, gaps included, against the reset values.
    task automatic chk_defaults();
        logic [23:0] v;
        for (int p = 8'h64; p <= 8'h7C; p++) begin
            host_i.rd(ADR, p[7:0], 1, v);
            chk(v, p == 8'h64 ? 24'h46 : p == 8'h65 ? 24'h5B :
                   (p == 8'h71 && boot_done) ? {16'h0000, FW_CODE} : 24'h0);
        end
        chk({8'h00, pll_fraction}, 24'h005B46);
        chk(frame_tally, 24'h000000);
        chk({23'h0, decode_run}, 24'h000000);
    endtask : chk_defaults

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; the host sets the run bit only after all set-up writes.
    initial begin
        logic ok;
        logic [23:0] v;
        logic [7:0] g [6] = '{8'h0C, 8'h0D, 8'hF4, 8'hF3, 8'h80, 8'h7F};
        logic [7:0] ofs [8] = '{OFS_FRAC_LO, OFS_FRAC_HI, OFS_HS_CORNER_LO, OFS_HS_CORNER_HI,
                                OFS_LS_CORNER_LO, OFS_LS_CORNER_HI, OFS_HS_GAIN, OFS_LS_GAIN};
        logic [7:0] dat [8];
        logic [15:0] fr, tr, bs;
        int n;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_defaults();
        for (int i = 0; i < 4; i++) begin
            fr = 16'($random(seed));
            tr = 16'h03E8 + {2'b00, 14'($random(seed))};
            bs = 16'h0014 + {7'h00, 9'($random(seed))};
            dat = '{fr[7:0], fr[15:8], tr[7:0], tr[15:8], bs[7:0], bs[15:8],
                    i < 3 ? g[2 * i] : 8'($random(seed)), i < 3 ? g[2 * i + 1] : 8'($random(seed))};
            foreach (ofs[k]) host_i.wr(ADR, ofs[k], dat[k], ok);
            foreach (ofs[k]) begin
                host_i.rd(ADR, ofs[k], 1, v);
                chk(v, {16'h0000, dat[k]});
            end
            chk({8'h00, pll_fraction}, {8'h00, fr});
            chk({8'h00, high_shelf_corner}, {8'h00, tr});
            chk({8'h00, low_shelf_corner}, {8'h00, bs});
            chk({16'h0000, high_shelf_gain}, {16'h0000, clamp(dat[6])});
            chk({16'h0000, low_shelf_gain}, {16'h0000, clamp(dat[7])});
        end
        host_i.wr(ADR, OFS_TALLY_LO, 8'h5A, ok);
        chk({23'h0, ok}, 24'h1);
        // A two-byte write in one transfer must land in consecutive offsets.
        host_i.wr2(ADR, OFS_LS_CORNER_LO, 16'h00C8, ok);
        chk({7'h00, ok, low_shelf_corner}, {8'h01, 16'h00C8});
        host_i.wr(ADR ^ 7'h01, OFS_DECODE_GO, 8'h01, ok);
        chk({22'h0, ok, decode_run}, 24'h0);
        host_i.wr(ADR, OFS_DECODE_GO, 8'hFF, ok);
        host_i.rd(ADR, OFS_DECODE_GO, 1, v);
        chk({v[22:0], decode_run}, 24'h3);
        // A random burst of back-to-back frames, read back as one low-to-high burst.
        n = 1 + ($unsigned($random(seed)) % 20);
        bitrate_kbps <= 8'($random(seed));
        @(posedge clk);
        frame_decoded <= 1'b1;
        repeat (n) @(posedge clk);
        frame_decoded <= 1'b0;
        host_i.rd(ADR, OFS_TALLY_LO, 3, v);
        chk(v, 24'(n));
        host_i.rd(ADR, OFS_MEAN_RATE, 1, v);
        chk(v, {16'h0000, bitrate_kbps});
        // Boot completes and frame sync loads the operating fraction.
        boot_done <= 1'b1;
        sync_fraction <= 16'($random(seed));
        frame_sync <= 1'b1;
        repeat (3) @(posedge clk);
        chk({8'h00, pll_fraction}, {8'h00, sync_fraction});
        frame_sync <= 1'b0;
        host_i.rd(ADR, OFS_FW_VERSION, 1, v);
        chk(v, {16'h0000, FW_CODE});
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        chk_defaults();
        give_verdict();
    end

    // The run needs about 37000 clocks; a hang is cut short well after that.
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule : dcr_control_regs_test

`default_nettype wire
